// ### shared/ext_mem_pkg.sv
// constants, states and the state record of the external memory interface
`default_nettype none
package ext_mem_pkg;
    // ---------------------------------------------------------------
    // widths and bus layout
    // ---------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam int DATA_W = 24;
    localparam int DMEM_LSB = 8;
    localparam int DMEM_W = 16;
    localparam int BOOT_BYTE_LSB = 8;
    localparam int BOOT_BYTE_W = 8;
    localparam int BOOT_PAGE_LSB = 22;
    localparam int BOOT_OFF_W = 13;
    localparam int SYNC_W = 27;
    localparam int SYNC_REQ = 24;
    localparam int SYNC_MAP = 25;
    localparam int SYNC_SRC = 26;
    localparam logic [DATA_W-1:0] OE_ALL_OFF = 24'hffffff;
    localparam logic [DATA_W-1:0] OE_BOOT = 24'h3fffff;
    localparam logic [DATA_W-1:0] OE_DMEM = 24'h0000ff;
    localparam logic [DATA_W-1:0] OE_PMD = 24'h000000;
    // ---------------------------------------------------------------
    // timing and counts
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam logic [2:0] SYNC_DELAY = 3'h2;
    localparam logic [2:0] BOOT_WAIT_RESET = 3'h3;
    localparam logic [2:0] EXT_WAIT = 3'h0;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    localparam logic [1:0] LAST_BYTE = 2'h2;
    localparam logic [2:0] BOOT_PAGE_RESET = 3'h0;
    localparam logic [ADDR_W-1:0] BOOT_WORDS = 14'h0020;
    // ---------------------------------------------------------------
    // states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_RELEASE, ST_GRANTED} bus_state_t;
    typedef enum logic [1:0] {BOOT_STRAP, BOOT_EPROM, BOOT_HOST, BOOT_DONE} boot_phase_t;
    typedef struct packed {
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        bus_state_t bus;
        boot_phase_t boot;
        logic [1:0] settle;
        logic [2:0] wait_cnt;
        logic boot_acc;
        logic acc_dm;
        logic [1:0] byte_idx;
        logic [BOOT_OFF_W-1:0] boot_off;
        logic [ADDR_W-1:0] word_idx;
        logic [2:0] page;
        logic [15:0] shift;
        logic [ADDR_W-1:0] addr;
        logic addr_oe_b;
        logic [DATA_W-1:0] data_o;
        logic [DATA_W-1:0] data_oe_b;
        logic pm_sel_b;
        logic dm_sel_b;
        logic boot_sel_b;
        logic rd_b;
        logic wr_b;
        logic strobe_oe_b;
        logic grant_b;
        logic halt;
        logic ack;
        logic [DATA_W-1:0] rdata;
        logic pm_we;
        logic [ADDR_W-1:0] pm_addr;
        logic [DATA_W-1:0] pm_data;
        logic boot_busy;
        logic host_boot;
    } state_t;
endpackage
`default_nettype wire

// ### verilog/ext_mem_if.sv
// external memory interface: boot loader, core accesses and bus grant
// Notes on behaviour
// - go mode set: once boot is done, core keeps running from internal memory while buses are granted
// - go mode clear: core halts for the whole time the buses are granted
// - boot logic fills program memory from a byte-wide memory by itself
// - boot byte reads use three wait states after reset
// - boot reads take data as input; two top data lines carry page bits
// - one 14-bit address bus serves program, data and boot memory
// - 24-bit two-way data bus; data memory uses the upper 16 bits
// - separate active-low selects for program, data, boot; separate read and write
// - boot source select 0 means byte-wide memory, 1 means host port
// - reset returns the whole block to its initial state
// - a later reset with unchanged clock needs no stabilisation wait
// - request with no access: three-state buses next cycle, then assert grant
// - memory map select 0 with boot source select 0 starts boot from page 0 after reset
// - request during boot is granted only after the current byte
`default_nettype none
module ext_mem_if
    import ext_mem_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic bus_request_b_in,
    input wire logic memory_map_select_in,
    input wire logic boot_source_select_in,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic go_mode_in,
    input wire logic host_boot_done_in,
    input wire logic mem_req_in,
    input wire logic mem_dm_in,
    input wire logic mem_we_in,
    input wire logic [ADDR_W-1:0] mem_addr_in,
    input wire logic [DATA_W-1:0] mem_wdata_in,
    output logic [ADDR_W-1:0] addr_out,
    output logic addr_oe_b_out,
    output logic [DATA_W-1:0] data_out,
    output logic [DATA_W-1:0] data_oe_b_out,
    output logic program_memory_select_b_out,
    output logic data_memory_select_b_out,
    output logic boot_memory_select_b_out,
    output logic read_b_out,
    output logic write_b_out,
    output logic strobe_oe_b_out,
    output logic bus_grant_b_out,
    output logic core_halt_out,
    output logic mem_ack_out,
    output logic [DATA_W-1:0] mem_rdata_out,
    output logic pm_load_we_out,
    output logic [ADDR_W-1:0] pm_load_addr_out,
    output logic [DATA_W-1:0] pm_load_data_out,
    output logic boot_busy_out,
    output logic host_boot_out
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    state_t q;
    state_t d;
    logic req_s;
    logic map_s;
    logic src_s;
    logic [BOOT_BYTE_W-1:0] boot_byte;

    assign req_s = q.sync2[SYNC_REQ];
    assign map_s = q.sync2[SYNC_MAP];
    assign src_s = q.sync2[SYNC_SRC];
    assign boot_byte = q.sync2[BOOT_BYTE_LSB +: BOOT_BYTE_W];

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        d = q;
        d.ack = 1'b0;
        d.pm_we = 1'b0;
        // request is stored active high so the reset value means idle
        d.sync1 = {boot_source_select_in, memory_map_select_in, ~bus_request_b_in, data_in};
        d.sync2 = q.sync1;
        case (q.boot)
            BOOT_STRAP: begin
                if (q.settle == STRAP_SETTLE) begin
                    if (map_s) begin
                        d.boot = BOOT_DONE;
                    end else if (src_s) begin
                        d.boot = BOOT_HOST;
                    end else begin
                        d.boot = BOOT_EPROM;
                    end
                end else begin
                    d.settle = q.settle + 2'h1;
                end
            end
            BOOT_HOST: begin
                if (host_boot_done_in) begin
                    d.boot = BOOT_DONE;
                end
            end
            default: begin
            end
        endcase
        case (q.bus)
            ST_IDLE: begin
                if (req_s) begin
                    d.bus = ST_RELEASE;
                    d.addr_oe_b = 1'b1;
                    d.strobe_oe_b = 1'b1;
                    d.data_oe_b = OE_ALL_OFF;
                end else if (q.boot == BOOT_EPROM) begin
                    // page on top data lines and top address line
                    d.bus = ST_ACCESS;
                    d.boot_acc = 1'b1;
                    d.addr = {q.page[0], q.boot_off};
                    d.data_o = '0;
                    d.data_o[BOOT_PAGE_LSB +: 2] = q.page[2:1];
                    d.data_oe_b = OE_BOOT;
                    d.boot_sel_b = 1'b0;
                    d.rd_b = 1'b0;
                    // boot wait states plus input sync delay
                    d.wait_cnt = BOOT_WAIT_RESET + SYNC_DELAY;
                end else if (q.boot == BOOT_DONE && mem_req_in && !q.ack) begin
                    // core access to program or data memory
                    d.bus = ST_ACCESS;
                    d.boot_acc = 1'b0;
                    d.acc_dm = mem_dm_in;
                    d.addr = mem_addr_in;
                    d.pm_sel_b = mem_dm_in;
                    d.dm_sel_b = !mem_dm_in;
                    d.rd_b = mem_we_in;
                    d.wr_b = !mem_we_in;
                    d.data_o = mem_dm_in ? {mem_wdata_in[DMEM_W-1:0], 8'h00} : mem_wdata_in;
                    d.data_oe_b = !mem_we_in ? OE_ALL_OFF : (mem_dm_in ? OE_DMEM : OE_PMD);
                    d.wait_cnt = EXT_WAIT + SYNC_DELAY;
                end
            end
            ST_ACCESS: begin
                if (q.wait_cnt != 3'h0) begin
                    d.wait_cnt = q.wait_cnt - 3'h1;
                end else begin
                    d.bus = ST_IDLE;
                    d.pm_sel_b = 1'b1;
                    d.dm_sel_b = 1'b1;
                    d.boot_sel_b = 1'b1;
                    d.rd_b = 1'b1;
                    d.wr_b = 1'b1;
                    d.data_oe_b = OE_ALL_OFF;
                    if (q.boot_acc) begin
                        // pack three bytes, high byte first, into one word
                        d.boot_off = q.boot_off + 13'h1;
                        if (q.byte_idx == LAST_BYTE) begin
                            d.byte_idx = 2'h0;
                            d.pm_we = 1'b1;
                            d.pm_addr = q.word_idx;
                            d.pm_data = {q.shift, boot_byte};
                            d.word_idx = q.word_idx + 14'h1;
                            if (q.word_idx == BOOT_WORDS - 14'h1) begin
                                d.boot = BOOT_DONE;
                            end
                        end else begin
                            d.byte_idx = q.byte_idx + 2'h1;
                            d.shift = {q.shift[7:0], boot_byte};
                        end
                    end else begin
                        d.ack = 1'b1;
                        d.rdata = q.acc_dm ? {8'h00, q.sync2[DMEM_LSB +: DMEM_W]}
                                           : q.sync2[DATA_W-1:0];
                    end
                end
            end
            ST_RELEASE: begin
                d.bus = ST_GRANTED;
                d.grant_b = 1'b0;
            end
            default: begin
                if (!req_s) begin
                    d.bus = ST_IDLE;
                    d.grant_b = 1'b1;
                    d.addr_oe_b = 1'b0;
                    d.strobe_oe_b = 1'b0;
                end
            end
        endcase
        // halt while granted unless go mode lets the core run on
        d.halt = (d.boot != BOOT_DONE) ||
            (((d.bus == ST_RELEASE) || (d.bus == ST_GRANTED)) && (!go_mode_in || mem_req_in));
        d.boot_busy = (d.boot != BOOT_DONE);
        d.host_boot = (d.boot == BOOT_HOST);
        // synchronous reset; clock keeps running through it
        if (!rst_b_in) begin
            d = '0;
            d.data_oe_b = OE_ALL_OFF;
            d.pm_sel_b = 1'b1;
            d.dm_sel_b = 1'b1;
            d.boot_sel_b = 1'b1;
            d.rd_b = 1'b1;
            d.wr_b = 1'b1;
            d.grant_b = 1'b1;
            d.halt = 1'b1;
            d.boot_busy = 1'b1;
            d.page = BOOT_PAGE_RESET;
        end
    end

    always_ff @(posedge mclk_in) begin
        q <= d;
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign addr_out = q.addr;
    assign addr_oe_b_out = q.addr_oe_b;
    assign data_out = q.data_o;
    assign data_oe_b_out = q.data_oe_b;
    assign program_memory_select_b_out = q.pm_sel_b;
    assign data_memory_select_b_out = q.dm_sel_b;
    assign boot_memory_select_b_out = q.boot_sel_b;
    assign read_b_out = q.rd_b;
    assign write_b_out = q.wr_b;
    assign strobe_oe_b_out = q.strobe_oe_b;
    assign bus_grant_b_out = q.grant_b;
    assign core_halt_out = q.halt;
    assign mem_ack_out = q.ack;
    assign mem_rdata_out = q.rdata;
    assign pm_load_we_out = q.pm_we;
    assign pm_load_addr_out = q.pm_addr;
    assign pm_load_data_out = q.pm_data;
    assign boot_busy_out = q.boot_busy;
    assign host_boot_out = q.host_boot;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_RELEASE_THEN_GRANT: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (q.bus == ST_IDLE && req_s) |=> (addr_oe_b_out && strobe_oe_b_out && data_oe_b_out == OE_ALL_OFF)
            ##1 !bus_grant_b_out)
        else $error("grant not preceded by released drivers");
    AST_GRANT_AFTER_FLOAT: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        $fell(bus_grant_b_out) |-> $past(addr_oe_b_out) && $past(strobe_oe_b_out))
        else $error("grant asserted while buses driven");
    AST_HALT_NO_GO: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (!bus_grant_b_out && !$past(go_mode_in)) |-> core_halt_out)
        else $error("core not halted during grant");
    AST_RUN_IN_GO: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (!bus_grant_b_out && $past(go_mode_in) && !$past(mem_req_in) && !boot_busy_out)
            |-> !core_halt_out)
        else $error("core halted in go mode");
    AST_BOOT_WAITS: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        $fell(boot_memory_select_b_out) |-> !boot_memory_select_b_out[*6] ##1 boot_memory_select_b_out)
        else $error("boot access length wrong");
    AST_BOOT_DATA_IN: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !boot_memory_select_b_out |-> data_oe_b_out == OE_BOOT && write_b_out && !read_b_out)
        else $error("boot access drives data bus");
    AST_DM_UPPER: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (!write_b_out && !data_memory_select_b_out) |-> data_oe_b_out == OE_DMEM)
        else $error("data memory write on wrong lanes");
    AST_BOOT_PAGE0: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (q.boot == BOOT_STRAP && q.settle == STRAP_SETTLE && !map_s && !src_s && !req_s)
            |=> ##1 (!boot_memory_select_b_out && !addr_out[ADDR_W-1] &&
                data_out[BOOT_PAGE_LSB +: 2] == 2'h0))
        else $error("boot did not start from page zero");
    AST_HOST_BOOT: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (q.boot == BOOT_STRAP && q.settle == STRAP_SETTLE && !map_s && src_s)
            |=> host_boot_out ##1 boot_memory_select_b_out)
        else $error("host boot not selected");
    AST_NO_GRANT_MID_BYTE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (q.bus == ST_ACCESS) |-> bus_grant_b_out)
        else $error("grant during access");
    AST_GIVE_BACK: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (q.bus == ST_GRANTED && !req_s) |=> bus_grant_b_out && !addr_oe_b_out && !strobe_oe_b_out)
        else $error("buses not reclaimed");
    AST_RESET_STATE: assert property (@(posedge mclk_in)
        !rst_b_in |=> bus_grant_b_out && core_halt_out && boot_busy_out && boot_memory_select_b_out)
        else $error("reset state wrong");
    COV_GRANT: cover property (@(posedge mclk_in) disable iff (!rst_b_in) $fell(bus_grant_b_out));
    COV_BOOT_DONE: cover property (@(posedge mclk_in) disable iff (!rst_b_in) $fell(boot_busy_out));
    COV_ACK: cover property (@(posedge mclk_in) disable iff (!rst_b_in) mem_ack_out);
    COV_GRANT_IN_BOOT: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
        !bus_grant_b_out && q.boot == BOOT_EPROM);
endmodule
`default_nettype wire

// ### tb/ext_mem_partner.sv
// behavioural external program, data and boot memories
`default_nettype none
module ext_mem_partner
    import ext_mem_pkg::*;
(
    input wire logic mclk_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic pm_sel_b_in,
    input wire logic dm_sel_b_in,
    input wire logic boot_sel_b_in,
    input wire logic rd_b_in,
    input wire logic wr_b_in,
    input wire logic strobe_oe_b_in,
    output logic [DATA_W-1:0] data_out,
    output logic [DATA_W-1:0] oe_b_out
);
    logic [DATA_W-1:0] pm_q [0:63];
    logic [DMEM_W-1:0] dm_q [0:63];
    logic [15:0] boot_addr;
    logic rd_on;
    logic wr_on;
    assign boot_addr = {data_in[23:22], addr_in};
    assign rd_on = !rd_b_in && !strobe_oe_b_in;
    assign wr_on = !wr_b_in && !strobe_oe_b_in;
    // ---------------------------------------------------------------
    // read side
    // ---------------------------------------------------------------
    // byte on D15:8, page bits alter it; dm on D23:8
    always_comb begin
        data_out = 24'h000000;
        oe_b_out = OE_ALL_OFF;
        if (rd_on && !boot_sel_b_in) begin
            data_out[15:8] = boot_addr[7:0] ^ {boot_addr[15:13], 5'h1a};
            oe_b_out = 24'hff00ff;
        end else if (rd_on && !dm_sel_b_in) begin
            data_out[23:8] = dm_q[addr_in[5:0]];
            oe_b_out = OE_DMEM;
        end else if (rd_on && !pm_sel_b_in) begin
            data_out = pm_q[addr_in[5:0]];
            oe_b_out = OE_PMD;
        end
    end
    // ---------------------------------------------------------------
    // write side
    // ---------------------------------------------------------------
    // write strobe stores 16 or 24 bits
    always_ff @(posedge mclk_in) begin
        if (wr_on && !dm_sel_b_in) begin
            dm_q[addr_in[5:0]] <= data_in[23:8];
        end
        if (wr_on && !pm_sel_b_in) begin
            pm_q[addr_in[5:0]] <= data_in;
        end
    end
endmodule
`default_nettype wire

// ### tb/ext_mem_if_tb_top.sv
// self-checking bench of the external memory interface
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module ext_mem_if_tb_top
    import ext_mem_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_in, rst_b_in, bus_request_b_in, memory_map_select_in, boot_source_select_in;
    logic go_mode_in, host_boot_done_in, mem_req_in, mem_dm_in, mem_we_in;
    logic [ADDR_W-1:0] mem_addr_in, addr_out, pm_load_addr_out;
    logic [DATA_W-1:0] mem_wdata_in, data_out, data_oe_b_out, mem_rdata_out, pm_load_data_out;
    logic [DATA_W-1:0] data_wire, mem_d, mem_oe_b, float_q;
    logic addr_oe_b_out, pm_sel_b, dm_sel_b, boot_sel_b, read_b_out, write_b_out, strobe_oe_b_out;
    logic bus_grant_b_out, core_halt_out, mem_ack_out, pm_load_we_out, boot_busy_out;
    logic host_boot_out;
    logic [4:0] sels;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    assign sels = {pm_sel_b, dm_sel_b, boot_sel_b, read_b_out, write_b_out};
    // released data lines show the inverse of their last level
    assign data_wire = (~data_oe_b_out & data_out) | (data_oe_b_out & ~mem_oe_b & mem_d)
        | (data_oe_b_out & mem_oe_b & float_q);
    initial float_q = 24'h000000;
    always @(posedge mclk_in) float_q <= ~data_wire;
    ext_mem_if i_ext_mem_if (
        .mclk_in, .rst_b_in, .bus_request_b_in, .memory_map_select_in, .boot_source_select_in,
        .data_in(data_wire), .go_mode_in, .host_boot_done_in, .mem_req_in, .mem_dm_in,
        .mem_we_in, .mem_addr_in, .mem_wdata_in, .addr_out, .addr_oe_b_out, .data_out,
        .data_oe_b_out, .program_memory_select_b_out(pm_sel_b),
        .data_memory_select_b_out(dm_sel_b),
        .boot_memory_select_b_out(boot_sel_b), .read_b_out, .write_b_out, .strobe_oe_b_out,
        .bus_grant_b_out, .core_halt_out, .mem_ack_out, .mem_rdata_out, .pm_load_we_out,
        .pm_load_addr_out, .pm_load_data_out, .boot_busy_out, .host_boot_out
    );
    ext_mem_partner i_ext_mem_partner (
        .mclk_in, .addr_in(addr_out), .data_in(data_wire), .pm_sel_b_in(pm_sel_b),
        .dm_sel_b_in(dm_sel_b), .boot_sel_b_in(boot_sel_b), .rd_b_in(read_b_out),
        .wr_b_in(write_b_out),
        .strobe_oe_b_in(strobe_oe_b_out), .data_out(mem_d), .oe_b_out(mem_oe_b)
    );
    // ---------------------------------------------------------------
    // clock, hang guard, helpers
    // ---------------------------------------------------------------
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic tk();
        @(posedge mclk_in);
        #1;
    endtask
    task automatic wait_for(ref logic s, input logic v);
        for (int n = 0; n < 20 && s !== v; n++) tk();
    endtask
    function automatic logic [7:0] boot_byte(input int a);
        return a[7:0] ^ 8'h1a;
    endfunction
    // no clock lock to wait for here
    task automatic do_reset(input logic map_sel, input logic src_sel);
        rst_b_in = 1'b0;
        memory_map_select_in = map_sel;
        boot_source_select_in = src_sel;
        repeat (5) tk();
        `CHK("reset strobes", 3'h7, {read_b_out, write_b_out, bus_grant_b_out})
        `CHK("reset data oe", OE_ALL_OFF, data_oe_b_out)
        `CHK("reset halt", 3'h6, {core_halt_out, boot_busy_out, mem_ack_out})
        rst_b_in = 1'b1;
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_boot(input int req_at);
        int words = 0;
        int run = 0;
        int last_run = 0;
        logic seen = 1'b0;
        for (int i = 0; i < 3000 && boot_busy_out === 1'b1; i++) begin
            tk();
            if (i == req_at) bus_request_b_in = 1'b0;
            if (boot_sel_b === 1'b0) begin
                run++;
                `CHK("boot page", 3'h0, {data_out[23:22], addr_out[13]})
                `CHK("boot data oe", OE_BOOT, data_oe_b_out)
            end else if (run != 0) begin
                `CHK("boot byte length", 6, run)
                last_run = run;
                run = 0;
            end
            if (pm_load_we_out === 1'b1) begin
                `CHK("boot word addr", words[ADDR_W-1:0], pm_load_addr_out)
                `CHK("boot word", {boot_byte(3*words), boot_byte(3*words+1),
                    boot_byte(3*words+2)}, pm_load_data_out)
                words++;
            end
            if (bus_grant_b_out === 1'b0 && bus_request_b_in === 1'b0) begin
                `CHK("grant after byte", 64'd6, {run, last_run})
                `CHK("grant halts", 1'b1, core_halt_out)
                seen = 1'b1;
                bus_request_b_in = 1'b1;
            end
        end
        `CHK("boot words", BOOT_WORDS, words[ADDR_W-1:0])
        `CHK("boot grant seen", 2'h2, {seen, boot_busy_out})
        $display("test boot done");
    endtask
    task automatic mem_op(input logic dm, input logic we, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
        int n = 0;
        mem_dm_in = dm;
        mem_we_in = we;
        mem_addr_in = a;
        mem_wdata_in = wd;
        mem_req_in = 1'b1;
        while (mem_ack_out !== 1'b1 && n < 20) begin
            tk();
            n++;
            if (n == 2) begin
                `CHK("access addr", a, addr_out)
                `CHK("access selects", {dm, ~dm, 1'b1, we, ~we}, sels)
                `CHK("access oe", !we ? OE_ALL_OFF : dm ? OE_DMEM : OE_PMD, data_oe_b_out)
            end
        end
        `CHK("ack latency", 4, n)
        rd = mem_rdata_out;
        mem_req_in = 1'b0;
        tk();
    endtask
    task automatic t_mem();
        logic [DATA_W-1:0] r;
        mem_op(1'b0, 1'b1, 14'h0005, 24'ha5c3e1, r);
        mem_op(1'b1, 1'b1, 14'h3ffe, 24'h77beef, r);
        mem_op(1'b0, 1'b0, 14'h0005, 24'h000000, r);
        `CHK("pm read", 24'ha5c3e1, r)
        mem_op(1'b1, 1'b0, 14'h3ffe, 24'h000000, r);
        `CHK("dm read", 24'h00beef, r)
        $display("test memory done");
    endtask
    task automatic t_grant(input logic go);
        int n = 0;
        logic off = 1'b0;
        logic [DATA_W-1:0] r;
        go_mode_in = go;
        bus_request_b_in = 1'b0;
        while (bus_grant_b_out !== 1'b0 && n < 10) begin
            off = addr_oe_b_out & strobe_oe_b_out;
            tk();
            n++;
        end
        `CHK("off before grant", 1'b1, off)
        `CHK("granted pins", {2'h3, OE_ALL_OFF}, {addr_oe_b_out, strobe_oe_b_out, data_oe_b_out})
        `CHK("halt while granted", ~go, core_halt_out)
        repeat (3) tk();
        `CHK("grant held", 1'b0, bus_grant_b_out)
        bus_request_b_in = 1'b1;
        wait_for(bus_grant_b_out, 1'b1);
        `CHK("grant dropped", 3'h4, {bus_grant_b_out, addr_oe_b_out, strobe_oe_b_out})
        tk();
        `CHK("resumed", 1'b0, core_halt_out)
        mem_op(1'b0, 1'b0, 14'h0005, 24'h000000, r);
        `CHK("read after grant", 24'ha5c3e1, r)
        go_mode_in = 1'b0;
        $display("test grant done");
    endtask
    task automatic t_host();
        do_reset(1'b0, 1'b1);
        repeat (8) tk();
        `CHK("host boot", 3'h7, {host_boot_out, boot_busy_out, boot_sel_b})
        host_boot_done_in = 1'b1;
        tk();
        host_boot_done_in = 1'b0;
        wait_for(boot_busy_out, 1'b0);
        `CHK("host boot end", 1'b0, boot_busy_out)
        $display("test host boot done");
    endtask
    task automatic t_nomap();
        logic [DATA_W-1:0] r;
        do_reset(1'b1, 1'b0);
        wait_for(boot_busy_out, 1'b0);
        `CHK("no boot", 2'h1, {boot_busy_out, boot_sel_b})
        mem_op(1'b0, 1'b0, 14'h0005, 24'h000000, r);
        `CHK("read no boot", 24'ha5c3e1, r)
        $display("test no boot done");
    endtask
    initial begin
        rst_b_in = 1'b0;
        bus_request_b_in = 1'b1;
        memory_map_select_in = 1'b0;
        boot_source_select_in = 1'b0;
        go_mode_in = 1'b0;
        host_boot_done_in = 1'b0;
        mem_req_in = 1'b0;
        mem_dm_in = 1'b0;
        mem_we_in = 1'b0;
        mem_addr_in = 14'h0000;
        mem_wdata_in = 24'h000000;
        do_reset(1'b0, 1'b0);
        t_boot(100);
        t_mem();
        t_grant(1'b0);
        t_grant(1'b1);
        t_host();
        t_nomap();
        end_of_test();
    end
endmodule
`default_nettype wire
